// *** hdl/srm_buf2.sv ***
// Two-entry buffer with valid and ready on both sides.
module srm_buf2 #(
  parameter type item_t = logic [7:0],
  parameter int  DEPTH  = 2
) (
  // Clock and reset.
  input  wire logic  mclk,
  input  wire logic  rst,
  // Filling side.
  input  wire logic  in_valid,
  output logic       in_ready,
  input  wire item_t in_item,
  // Draining side.
  output logic       out_valid,
  input  wire logic  out_ready,
  output item_t      out_item
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  item_t              mem [DEPTH];
  logic [PW-1:0]      wr_ptr;
  logic [PW-1:0]      rd_ptr;
  logic [PW:0]        count;
  logic               push;
  logic               pop;

  // Full and empty follow the count exactly.
  assign in_ready  = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_item  = mem[rd_ptr];

  // Storage is written at the write pointer.
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_item;
    end
  end

  // Pointers wrap at the depth.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
      end
    end
  end

  // Occupancy count.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + (PW+1)'(1);
    end else if (pop && !push) begin
      count <= count - (PW+1)'(1);
    end
  end

endmodule

// *** hdl/srm_pkg.sv ***
package srm_pkg;

  // Register indices of the two receive channel configuration registers.
  localparam logic [7:0] RX_CH3_CFG_ADDR = 8'h2A;
  localparam logic [7:0] RX_CH4_CFG_ADDR = 8'h2B;

  // Field positions inside a configuration register.
  localparam int ENABLE_BIT  = 5;
  localparam int SLOT_MSB    = 4;
  localparam int SLOT_LSB    = 0;
  localparam int RSVD_MSB    = 7;
  localparam int RSVD_LSB    = 6;
  localparam int HALF_BIT    = 4;

  // Reset values of the fields.
  localparam logic       RX_CH3_ENABLE_RST = 1'h0;
  localparam logic       RX_CH4_ENABLE_RST = 1'h0;
  localparam logic [4:0] RX_CH3_SLOT_RST   = 5'h02;
  localparam logic [4:0] RX_CH4_SLOT_RST   = 5'h03;
  localparam logic [1:0] RSVD_VALUE        = 2'h0;

  // Playback converter channel codes carried with each word.
  localparam logic PLAY_CH3 = 1'h0;
  localparam logic PLAY_CH4 = 1'h1;

  localparam int SAMPLE_W = 32;

  // Stored configuration of one receive channel.
  typedef struct packed {
    logic       enable;
    logic [4:0] slot;
  } srm_cfg_t;

  // One received slot word as the deserialiser hands it over.
  typedef struct packed {
    logic [4:0]          idx;
    logic                right;
    logic [SAMPLE_W-1:0] data;
  } srm_slot_t;

  // One word toward the playback path.
  typedef struct packed {
    logic                chan;
    logic [SAMPLE_W-1:0] data;
  } srm_play_t;

endpackage

// *** hdl/srm_slot_map.sv ***
module srm_slot_map (
  // Clock and reset.
  input  wire logic                mclk,
  input  wire logic                rst,
  // Register access port.
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  output logic [7:0]               reg_rdata,
  // Frame format: high for TDM, low for I2S or left-justified.
  input  wire logic                fmt_tdm,
  // Slot stream from the primary serial port deserialiser.
  input  wire logic                slot_valid,
  output logic                     slot_ready,
  input  wire srm_pkg::srm_slot_t  slot_word,
  // Words toward the playback converters.
  output logic                     play_valid,
  input  wire logic                play_ready,
  output srm_pkg::srm_play_t       play_word
);

  srm_pkg::srm_cfg_t   cfg3;
  srm_pkg::srm_cfg_t   cfg4;
  logic                hit3;
  logic                hit4;
  logic                slot_take;
  logic                stage_valid;
  logic                stage_hit3;
  logic                stage_hit4;
  logic [31:0]         stage_data;
  logic                buf_ready;
  logic                buf_push;
  srm_pkg::srm_play_t  buf_item;

  // Decides whether a received slot matches a configured slot number.
  function automatic logic slot_match(input logic [4:0] sel, input logic tdm, input logic [4:0] idx,
                                      input logic right);
    if (tdm) begin
      slot_match = (sel == idx);
    end else begin
      slot_match = (sel[srm_pkg::HALF_BIT] == right) && (sel[3:0] == idx[3:0]);
    end
  endfunction

  // Register writes keep the enable and slot fields only.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg3.enable <= srm_pkg::RX_CH3_ENABLE_RST;
      cfg3.slot   <= srm_pkg::RX_CH3_SLOT_RST;
      cfg4.enable <= srm_pkg::RX_CH4_ENABLE_RST;
      cfg4.slot   <= srm_pkg::RX_CH4_SLOT_RST;
    end else if (reg_wr) begin
      if (reg_addr == srm_pkg::RX_CH3_CFG_ADDR) begin
        cfg3.enable <= reg_wdata[srm_pkg::ENABLE_BIT];
        cfg3.slot   <= reg_wdata[srm_pkg::SLOT_MSB:srm_pkg::SLOT_LSB];
      end
      if (reg_addr == srm_pkg::RX_CH4_CFG_ADDR) begin
        cfg4.enable <= reg_wdata[srm_pkg::ENABLE_BIT];
        cfg4.slot   <= reg_wdata[srm_pkg::SLOT_MSB:srm_pkg::SLOT_LSB];
      end
    end
  end

  // Read data is registered; reserved bits and unmapped addresses read zero.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == srm_pkg::RX_CH3_CFG_ADDR) begin
        reg_rdata <= {srm_pkg::RSVD_VALUE, cfg3};
      end else if (reg_addr == srm_pkg::RX_CH4_CFG_ADDR) begin
        reg_rdata <= {srm_pkg::RSVD_VALUE, cfg4};
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // A disabled channel never matches, so its slot is dropped.
  assign hit3       = cfg3.enable && slot_match(cfg3.slot, fmt_tdm, slot_word.idx, slot_word.right);
  assign hit4       = cfg4.enable && slot_match(cfg4.slot, fmt_tdm, slot_word.idx, slot_word.right);
  assign slot_ready = !stage_valid;
  assign slot_take  = slot_valid && slot_ready;

  // Channel 3 goes first when both channels share one slot.
  assign buf_push      = stage_valid && buf_ready;
  assign buf_item = {(stage_hit3 ? srm_pkg::PLAY_CH3 : srm_pkg::PLAY_CH4), stage_data};

  // The stage holds one matched slot until every owed word is buffered.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stage_valid <= 1'b0;
      stage_hit3  <= 1'b0;
      stage_hit4  <= 1'b0;
    end else if (slot_take) begin
      stage_valid <= hit3 || hit4;
      stage_hit3  <= hit3;
      stage_hit4  <= hit4;
    end else if (buf_push) begin
      if (stage_hit3) begin
        stage_hit3  <= 1'b0;
        stage_valid <= stage_hit4;
      end else begin
        stage_hit4  <= 1'b0;
        stage_valid <= 1'b0;
      end
    end
  end

  // Sample data of the staged slot.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stage_data <= 32'h0;
    end else if (slot_take) begin
      stage_data <= slot_word.data;
    end
  end

  // Output buffer absorbs a stall by the playback path.
  srm_buf2 #(
    .item_t (srm_pkg::srm_play_t),
    .DEPTH  (2)
  ) u_buf (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (stage_valid),
    .in_ready  (buf_ready),
    .in_item   (buf_item),
    .out_valid (play_valid),
    .out_ready (play_ready),
    .out_item  (play_word)
  );

  // Checks.
  AST_RSVD_ZERO: assert property (@(posedge mclk) disable iff (rst)
    reg_rd |=> reg_rdata[srm_pkg::RSVD_MSB:srm_pkg::RSVD_LSB] == 2'h0)
    else $error("Reserved bits read nonzero.");

  AST_CH3_OFF: assert property (@(posedge mclk) disable iff (rst)
    (slot_take && !cfg3.enable) |=> !stage_hit3)
    else $error("Disabled channel 3 took a slot.");

  AST_CH4_OFF: assert property (@(posedge mclk) disable iff (rst)
    (slot_take && !cfg4.enable) |=> !stage_hit4)
    else $error("Disabled channel 4 took a slot.");

  AST_CH3_SLOT: assert property (@(posedge mclk) disable iff (rst)
    (reg_wr && reg_addr == srm_pkg::RX_CH3_CFG_ADDR) ##1 !reg_wr
    ##1 (reg_rd && reg_addr == srm_pkg::RX_CH3_CFG_ADDR)
    |=> reg_rdata[4:0] == $past(reg_wdata[4:0], 3))
    else $error("Channel 3 slot readback mismatch.");

  AST_CH4_SLOT: assert property (@(posedge mclk) disable iff (rst)
    $fell(rst) |-> cfg4.slot == srm_pkg::RX_CH4_SLOT_RST && cfg3.slot == srm_pkg::RX_CH3_SLOT_RST)
    else $error("Slot reset value wrong.");

  AST_I2S_RIGHT: assert property (@(posedge mclk) disable iff (rst)
    (slot_take && cfg3.enable && !fmt_tdm && slot_word.right && cfg3.slot[4] &&
     slot_word.idx[3:0] == cfg3.slot[3:0]) |=> stage_valid && stage_hit3 && stage_data == $past(slot_word.data))
    else $error("Right-half slot not mapped to channel 3.");

  AST_TDM_SLOT: assert property (@(posedge mclk) disable iff (rst)
    (slot_take && cfg4.enable && fmt_tdm && slot_word.idx != cfg4.slot) |=> !stage_hit4)
    else $error("TDM slot mismatch accepted on channel 4.");

  AST_NO_SAMPLE: assert property (@(posedge mclk) disable iff (rst)
    (slot_take && !cfg3.enable && !cfg4.enable) |=> !stage_valid && !stage_hit3 && !stage_hit4)
    else $error("Sample emitted with both channels off.");

  // Slot selection, ordering, stall and read-data hold checks.
  AST_CH3_TDM: assert property (@(posedge mclk) disable iff (rst)
    (slot_take && cfg3.enable && fmt_tdm && slot_word.idx == cfg3.slot)
    |=> stage_valid && stage_hit3 && stage_data == $past(slot_word.data))
    else $error("Channel 3 missed its TDM slot.");

  AST_CH4_TDM: assert property (@(posedge mclk) disable iff (rst)
    (slot_take && cfg4.enable && fmt_tdm && slot_word.idx == cfg4.slot)
    |=> stage_valid && stage_hit4 && stage_data == $past(slot_word.data))
    else $error("Channel 4 missed its TDM slot.");

  AST_CH4_I2S: assert property (@(posedge mclk) disable iff (rst)
    (slot_take && cfg4.enable && !fmt_tdm && slot_word.right == cfg4.slot[srm_pkg::HALF_BIT] &&
     slot_word.idx[3:0] == cfg4.slot[3:0])
    |=> stage_valid && stage_hit4)
    else $error("Half-frame slot not mapped to channel 4.");

  AST_BOTH_ORDER: assert property (@(posedge mclk) disable iff (rst)
    (buf_push && stage_hit3 && stage_hit4)
    |-> buf_item.chan == srm_pkg::PLAY_CH3 ##1 (stage_valid && !stage_hit3 && stage_hit4))
    else $error("Shared slot not handed over channel 3 first.");

  AST_STALL_HOLD: assert property (@(posedge mclk) disable iff (rst)
    (stage_valid && !buf_ready)
    |=> stage_valid && $stable(stage_data) && !slot_ready)
    else $error("Staged slot lost during a stall.");

  AST_IDLE_OFF: assert property (@(posedge mclk) disable iff (rst)
    (!cfg3.enable && !cfg4.enable && !stage_valid)
    |=> !stage_valid)
    else $error("Slot staged with both channels off.");

  AST_RDATA_HOLD: assert property (@(posedge mclk) disable iff (rst)
    !reg_rd
    |=> $stable(reg_rdata))
    else $error("Read data changed without a read.");

  COV_CH3: cover property (@(posedge mclk) disable iff (rst) buf_push && buf_item.chan == srm_pkg::PLAY_CH3);
  COV_BOTH: cover property (@(posedge mclk) disable iff (rst) slot_take && hit3 && hit4);
  COV_STALL: cover property (@(posedge mclk) disable iff (rst) !buf_ready && stage_valid);
  // A right-half slot reaches channel 4, and an unmatched slot is dropped.
  COV_HALF_RIGHT: cover property (@(posedge mclk) disable iff (rst) slot_take && hit4 && !fmt_tdm && slot_word.right);
  COV_DROP: cover property (@(posedge mclk) disable iff (rst) slot_take && !hit3 && !hit4);

endmodule

// *** tb/srm_host_model.sv ***
// Slot source standing in for the audio host that drives the serial frames.
module srm_host_model (
  // Clock and reset.
  input  wire logic               mclk,
  input  wire logic               rst,
  // Request from the bench.
  input  wire logic               send,
  input  wire srm_pkg::srm_slot_t send_word,
  // Slot stream toward the block.
  output logic                    slot_valid,
  input  wire logic               slot_ready,
  output srm_pkg::srm_slot_t      slot_word
);
  timeunit 1ns;
  timeprecision 1ps;

  // Holds a word until it is taken; idle data toggles so no stale word is mistaken for fresh.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      slot_valid <= 1'h0;
      slot_word  <= '0;
    end else if (send) begin
      slot_valid <= 1'h1;
      slot_word  <= send_word;
    end else if (!slot_valid || slot_ready) begin
      slot_valid <= 1'h0;
      slot_word  <= ~slot_word;
    end
  end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the channel 3 and 4 slot mapping.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic       tdm;
    logic [7:0] c3;
    logic [7:0] c4;
    logic [4:0] idx;
    logic       rt;
    logic [1:0] n;
    logic       ch;
  } srm_row_t;
  logic               mclk = 1'h0;
  logic               rst = 1'h1;
  logic               reg_wr = 1'h0;
  logic               reg_rd = 1'h0;
  logic               fmt_tdm = 1'h1;
  logic               play_ready = 1'h1;
  logic               send = 1'h0;
  logic               slot_valid;
  logic               slot_ready;
  logic               play_valid;
  logic [7:0]         reg_addr = 8'h00;
  logic [7:0]         reg_wdata = 8'h00;
  logic [7:0]         reg_rdata;
  srm_pkg::srm_slot_t send_word = '0;
  srm_pkg::srm_slot_t slot_word;
  srm_pkg::srm_play_t play_word;
  srm_pkg::srm_play_t got[$];
  int                 fails = 0;
  int                 comparisons = 0;
  srm_row_t           rows [9];

  srm_slot_map u_dut (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fmt_tdm(fmt_tdm), .slot_valid(slot_valid),
    .slot_ready(slot_ready), .slot_word(slot_word), .play_valid(play_valid), .play_ready(play_ready),
    .play_word(play_word));
  srm_host_model u_host (.mclk(mclk), .rst(rst), .send(send), .send_word(send_word),
    .slot_valid(slot_valid), .slot_ready(slot_ready), .slot_word(slot_word));

  // The clock toggles every 2 ns, a period of 4 ns.
  always #2 mclk = ~mclk;

  // Every word the playback side accepts is recorded in order.
  always @(posedge mclk) begin
    if (play_valid && play_ready) got.push_back(play_word);
  end

  // Counts a comparison and reports a mismatch.
  task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // One register write strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask

  // One register read; data is looked at one cycle after the strobe is taken.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'h0;
    @(posedge mclk);
    #1 check("reg_rdata", 40'(reg_rdata), 40'(exp));
  endtask

  // Hands one word to the host model once its previous word is gone.
  task automatic send_slot(input srm_pkg::srm_slot_t w);
    do @(posedge mclk); while (slot_valid);
    send      <= 1'h1;
    send_word <= w;
    @(posedge mclk);
    send <= 1'h0;
  endtask

  // Waits a bounded time for a number of playback words.
  task automatic wait_words(input int n);
    for (int k = 0; k < 40 && got.size() < n; k++) @(posedge mclk);
    repeat (4) @(posedge mclk);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // A hang is cut short well after the expected run length.
  initial begin
    #(20000 * 4);
    fails++;
    wrap_up();
  end

  // Main sequence: reset, register checks, table of routing cases, stall, second reset.
  initial begin
    rows = '{'{1'h1, 8'h22, 8'h03, 5'h02, 1'h0, 2'h1, 1'h0}, '{1'h1, 8'h02, 8'h3F, 5'h1F, 1'h0, 2'h1, 1'h1},
             '{1'h0, 8'h31, 8'h03, 5'h01, 1'h1, 2'h1, 1'h0}, '{1'h0, 8'h2F, 8'h03, 5'h0F, 1'h0, 2'h1, 1'h0},
             '{1'h0, 8'h31, 8'h03, 5'h01, 1'h0, 2'h0, 1'h0}, '{1'h1, 8'h02, 8'h03, 5'h02, 1'h0, 2'h0, 1'h0},
             '{1'h1, 8'h25, 8'h25, 5'h05, 1'h0, 2'h2, 1'h0}, '{1'h1, 8'h02, 8'h33, 5'h03, 1'h0, 2'h0, 1'h0},
             '{1'h0, 8'h02, 8'h33, 5'h03, 1'h1, 2'h1, 1'h1}};
    repeat (5) @(posedge mclk);
    rst <= 1'h0;
    rd(srm_pkg::RX_CH3_CFG_ADDR, 8'h02);
    rd(srm_pkg::RX_CH4_CFG_ADDR, 8'h03);
    rd(8'h40, 8'h00);
    wr(srm_pkg::RX_CH3_CFG_ADDR, 8'h3F);
    rd(srm_pkg::RX_CH3_CFG_ADDR, 8'h3F);
    for (int i = 0; i < 9; i++) begin
      fmt_tdm <= rows[i].tdm;
      wr(srm_pkg::RX_CH3_CFG_ADDR, rows[i].c3);
      wr(srm_pkg::RX_CH4_CFG_ADDR, rows[i].c4);
      got.delete();
      send_slot({rows[i].idx, rows[i].rt, 24'hA50000, 8'(i)});
      wait_words(int'(rows[i].n));
      check("word count", 40'(got.size()), 40'(rows[i].n));
      if (got.size() > 0) check("chan", 40'(got[0].chan), 40'(rows[i].ch));
      if (got.size() > 0) check("data", 40'(got[0].data), {8'h0, 24'hA50000, 8'(i)});
      if (got.size() > 1) check("second chan", 40'(got[1].chan), 40'(srm_pkg::PLAY_CH4));
    end
    play_ready <= 1'h0;
    fmt_tdm    <= 1'h1;
    wr(srm_pkg::RX_CH3_CFG_ADDR, 8'h22);
    wr(srm_pkg::RX_CH4_CFG_ADDR, 8'h03);
    got.delete();
    for (int j = 0; j < 4; j++) send_slot({5'h02, 1'h0, 24'hB60000, 8'(j)});
    repeat (3) @(posedge mclk);
    #1 check("stalled slot_ready", 40'(slot_ready), 40'h0);
    check("stalled play_valid", 40'(play_valid), 40'h1);
    @(posedge mclk);
    play_ready <= 1'h1;
    wait_words(4);
    check("drained count", 40'(got.size()), 40'd4);
    for (int j = 0; j < 4 && j < got.size(); j++) check("drained data", 40'(got[j].data), {8'h0, 24'hB60000, 8'(j)});
    @(posedge mclk);
    rst <= 1'h1;
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    #1 check("play_valid after reset", 40'(play_valid), 40'h0);
    rd(srm_pkg::RX_CH3_CFG_ADDR, 8'h02);
    rd(srm_pkg::RX_CH4_CFG_ADDR, 8'h03);
    wrap_up();
  end
endmodule
